// ### bench/cmc_can_node.sv
module cmc_can_node #(
  parameter int BIT_CYC = 2
) (
  input  wire logic clk_sys,
  input  wire logic reset,
  input  wire logic bus_tx_pin,
  input  wire logic remote_dom,
  output logic      bus_rx_pin,
  output logic      rec11_seen
);
  timeunit 1ns;
  timeprecision 1ps;
  int unsigned cnt_q;
  // Wired-AND bus, pulled up to recessive
  assign bus_rx_pin = bus_tx_pin & ~remote_dom;
  ////////////////////////////////////////
  // Pulse per 11 recessive bit times
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      cnt_q <= 0;
      rec11_seen <= 1'b0;
    end else begin
      rec11_seen <= 1'b0;
      if (!bus_rx_pin) begin
        cnt_q <= 0;
      end else if (cnt_q == 11 * BIT_CYC - 1) begin
        cnt_q <= 0;
        rec11_seen <= 1'b1;
      end else begin
        cnt_q <= cnt_q + 1;
      end
    end
  end
endmodule

// ### bench/cmc_mode_ctrl_asserts.sv
module cmc_mode_ctrl_asserts (
  input wire logic       clk_sys,
  input wire logic       reset,
  input wire logic [7:0] reg_addr,
  input wire logic       reg_wr,
  input wire logic       cpu_stop,
  input wire logic       bus_idle,
  input wire logic       bus_off,
  input wire logic       eng_tx_bit,
  input wire logic       eng_rx_bit,
  input wire logic       bus_tx_pin,
  input wire logic       module_enable,
  input wire logic       loopback_test,
  input wire logic       listen_only,
  input wire logic       ack_err_send_en,
  input wire logic       err_cnt_freeze,
  input wire logic       tx_enable,
  input wire logic [1:0] sync_jump_width,
  input wire logic [5:0] baud_prescaler,
  input wire logic       frame_abort,
  input wire logic       sleep_mode,
  input wire logic       bus_synced
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  ////////////////////////////////////////
  property p_stop_tx; cpu_stop |-> bus_tx_pin; endproperty
  a_stop_tx: assert property (p_stop_tx)
    else $error("tx pin dominant in stop");
  property p_init_tx; frame_abort |-> bus_tx_pin; endproperty
  a_init_tx: assert property (p_init_tx)
    else $error("tx pin dominant with init request");
  property p_init_hold; $rose(frame_abort) |=> frame_abort; endproperty
  a_init_hold: assert property (p_init_hold)
    else $error("init request cleared before init reached");
  property p_loop;
    loopback_test |-> bus_tx_pin && eng_rx_bit == eng_tx_bit;
  endproperty
  a_loop: assert property (p_loop)
    else $error("loopback path wrong");
  property p_listen;
    listen_only |-> !ack_err_send_en && err_cnt_freeze && !tx_enable;
  endproperty
  a_listen: assert property (p_listen)
    else $error("listen only controls wrong");
  property p_off_tx; !module_enable |-> bus_tx_pin; endproperty
  a_off_tx: assert property (p_off_tx)
    else $error("disabled module drives tx");
  property p_btr_lock;
    reg_wr && reg_addr == 8'h02 && !frame_abort
      |=> $stable({sync_jump_width, baud_prescaler});
  endproperty
  a_btr_lock: assert property (p_btr_lock)
    else $error("bit timing changed outside init");
  property p_sleep_idle; !bus_idle && !sleep_mode |=> !sleep_mode; endproperty
  a_sleep_idle: assert property (p_sleep_idle)
    else $error("sleep entered while bus busy");
  property p_busoff_wait;
    $fell(frame_abort) && bus_off |-> !bus_synced [*8];
  endproperty
  a_busoff_wait: assert property (p_busoff_wait)
    else $error("bus-off resync too early");
endmodule

bind cmc_mode_ctrl cmc_mode_ctrl_asserts u_chk (
  .clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr), .reg_wr(reg_wr),
  .cpu_stop(cpu_stop), .bus_idle(bus_idle), .bus_off(bus_off),
  .eng_tx_bit(eng_tx_bit), .eng_rx_bit(eng_rx_bit), .bus_tx_pin(bus_tx_pin),
  .module_enable(module_enable), .loopback_test(loopback_test),
  .listen_only(listen_only), .ack_err_send_en(ack_err_send_en),
  .err_cnt_freeze(err_cnt_freeze), .tx_enable(tx_enable),
  .sync_jump_width(sync_jump_width), .baud_prescaler(baud_prescaler),
  .frame_abort(frame_abort), .sleep_mode(sleep_mode),
  .bus_synced(bus_synced));

// ### bench/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk_sys = 0, reset = 1, reg_wr = 0, reg_rd = 0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic       special_mode = 0, cpu_wait = 0, cpu_stop = 0, bus_idle = 1;
  logic       bus_off = 0, eng_tx_bit = 1, remote_dom = 0;
  logic [1:0] tx_state_field = 2'b10, rx_state_field = 2'b01;
  logic [1:0] sync_jump_width;
  logic [5:0] baud_prescaler;
  logic       rec11_seen, eng_rx_bit, bus_rx_pin, bus_tx_pin, module_enable;
  logic       clock_select, loopback_test, listen_only, ack_err_send_en;
  logic       err_cnt_freeze, tx_enable, busoff_recovery_policy;
  logic       frame_abort, sleep_mode, bus_synced, wake_event;
  int         mismatches = 0, tests_run = 0;
  always #2.5 clk_sys = ~clk_sys;
  cmc_mode_ctrl dut (.clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .special_mode(special_mode), .cpu_wait(cpu_wait),
    .cpu_stop(cpu_stop), .bus_idle(bus_idle), .bus_off(bus_off),
    .rec11_seen(rec11_seen), .tx_state_field(tx_state_field),
    .rx_state_field(rx_state_field), .eng_tx_bit(eng_tx_bit),
    .eng_rx_bit(eng_rx_bit), .bus_rx_pin(bus_rx_pin),
    .bus_tx_pin(bus_tx_pin), .module_enable(module_enable),
    .clock_select(clock_select), .loopback_test(loopback_test),
    .listen_only(listen_only), .ack_err_send_en(ack_err_send_en),
    .err_cnt_freeze(err_cnt_freeze), .tx_enable(tx_enable),
    .busoff_recovery_policy(busoff_recovery_policy),
    .sync_jump_width(sync_jump_width), .baud_prescaler(baud_prescaler),
    .frame_abort(frame_abort), .sleep_mode(sleep_mode),
    .bus_synced(bus_synced), .wake_event(wake_event));
  cmc_can_node #(.BIT_CYC(2)) node (.clk_sys(clk_sys), .reset(reset),
    .bus_tx_pin(bus_tx_pin), .remote_dom(remote_dom),
    .bus_rx_pin(bus_rx_pin), .rec11_seen(rec11_seen));
  ////////////////////////////////////////
  task automatic chk(string nm, logic [7:0] e, logic [7:0] got);
    tests_run++;
    if (got !== e) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", nm, e, got);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] m, logic [7:0] e, string nm);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 chk(nm, e, reg_rdata & m);
  endtask
  task automatic wt(ref logic s, input logic v, input int lim, string nm);
    int n = 0;
    while (s !== v && n < lim) begin
      @(posedge clk_sys);
      #1 n++;
    end
    chk(nm, 8'(v), 8'(s));
    if (s !== v) end_sim;
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  ////////////////////////////////////////
  task automatic t_reset;
    rd(8'h00, 8'hFF, 8'h00, "ctl0");
    rd(8'h01, 8'hFF, 8'h00, "ctl1");
    rd(8'h02, 8'hFF, 8'h00, "btr0");
    rd(8'h07, 8'hFF, 8'h00, "unmapped");
    chk("tx_off", 1, bus_tx_pin);
    wr(8'h02, 8'hC5);
    wr(8'h01, 8'h80);
    rd(8'h02, 8'hFF, 8'h00, "btr0_lock");
    rd(8'h01, 8'hFF, 8'h00, "ctl1_lock");
    $display("test reset done");
  endtask
  task automatic t_sleep;
    @(posedge clk_sys) bus_idle <= 1'b0;
    wr(8'h00, 8'h26);
    repeat (20) @(posedge clk_sys);
    #1 chk("sleep_busy", 0, sleep_mode);
    wr(8'h00, 8'h24);
    rd(8'h00, 8'hFF, 8'h26, "slp_kept");
    @(posedge clk_sys) bus_idle <= 1'b1;
    wt(sleep_mode, 1'b1, 20, "sleep_idle");
    rd(8'h01, 8'h03, 8'h02, "sleep_ack");
    $display("test sleep done");
  endtask
  task automatic t_init;
    wr(8'h00, 8'h27);
    rd(8'h01, 8'h01, 8'h01, "init_ack");
    rd(8'h00, 8'hFF, 8'h07, "ctl0_init");
    rd(8'h04, 8'hF0, 8'h60, "states");
    wr(8'h02, 8'hC5);
    rd(8'h02, 8'hFF, 8'hC5, "btr0");
    chk("sjw", 3, sync_jump_width);
    chk("brp", 5, baud_prescaler);
    wr(8'h01, 8'hB8);
    chk("en", 1, module_enable);
    chk("loop_en", 1, loopback_test);
    chk("clk_sel", 0, clock_select);
    chk("bo_pol", 1, busoff_recovery_policy);
    chk("listen", 1, listen_only);
    chk("ack_err", 0, ack_err_send_en);
    chk("freeze", 1, err_cnt_freeze);
    chk("tx_en", 0, tx_enable);
    @(posedge clk_sys) remote_dom <= 1'b1;
    #1 chk("loop_rx1", 1, eng_rx_bit);
    @(posedge clk_sys) eng_tx_bit <= 1'b0;
    #1 chk("loop_rx0", 0, eng_rx_bit);
    chk("loop_tx", 1, bus_tx_pin);
    wr(8'h01, 8'h44);
    chk("en_once", 1, module_enable);
    chk("clk_sel1", 1, clock_select);
    chk("bo_pol0", 0, busoff_recovery_policy);
    @(posedge clk_sys) special_mode <= 1'b1;
    wr(8'h01, 8'h04);
    chk("en_special", 0, module_enable);
    wr(8'h01, 8'h84);
    chk("en_again", 1, module_enable);
    @(posedge clk_sys) special_mode <= 1'b0;
    rd(8'h01, 8'hFD, 8'h85, "ctl1");
    $display("test init done");
  endtask
  task automatic t_resync(logic bo, logic [7:0] expn);
    int n = 0;
    int k = 0;
    @(posedge clk_sys);
    bus_off <= bo;
    remote_dom <= 1'b1;
    eng_tx_bit <= 1'b1;
    wr(8'h00, 8'h04);
    @(posedge clk_sys) remote_dom <= 1'b0;
    while (bus_synced !== 1'b1 && k < 4000) begin
      @(posedge clk_sys);
      #1 k++;
      if (rec11_seen === 1'b1) n++;
    end
    chk("resync_count", expn, 8'(n));
    if (bus_synced !== 1'b1) end_sim;
    @(posedge clk_sys) bus_off <= 1'b0;
    $display("test resync done");
  endtask
  task automatic t_pins;
    @(posedge clk_sys) eng_tx_bit <= 1'b0;
    #1 chk("tx_run", 0, bus_tx_pin);
    @(posedge clk_sys) cpu_stop <= 1'b1;
    #1 chk("tx_stop", 1, bus_tx_pin);
    @(posedge clk_sys);
    cpu_stop <= 1'b0;
    cpu_wait <= 1'b1;
    #1 chk("tx_wait", 0, bus_tx_pin);
    wr(8'h00, 8'h24);
    chk("tx_wait_siw", 1, bus_tx_pin);
    @(posedge clk_sys) cpu_wait <= 1'b0;
    wr(8'h02, 8'h3F);
    rd(8'h02, 8'hFF, 8'hC5, "btr0_run");
    wr(8'h01, 8'h00);
    chk("en_run", 1, module_enable);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= 8'h00;
    reg_wdata <= 8'h05;
    @(posedge clk_sys);
    reg_wdata <= 8'h04;
    #1 chk("tx_init_req", 1, bus_tx_pin);
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    #1 chk("init_hold", 1, frame_abort);
    $display("test pins done");
  endtask
  task automatic t_wake;
    int n = 0;
    chk("tx_en_run", 1, tx_enable);
    wr(8'h00, 8'h06);
    wt(sleep_mode, 1'b1, 20, "sleep_in");
    @(posedge clk_sys) remote_dom <= 1'b1;
    repeat (100) @(posedge clk_sys);
    remote_dom <= 1'b0;
    #1 chk("short_pulse", 1, sleep_mode);
    @(posedge clk_sys) remote_dom <= 1'b1;
    while (wake_event !== 1'b1 && n < 600) begin
      @(posedge clk_sys);
      #1 n++;
    end
    chk("wake_time", 1, 8'(n >= cmc_pkg::WAKE_PULSE_CYCLES - 2 &&
        n <= cmc_pkg::WAKE_PULSE_CYCLES + 2));
    if (wake_event !== 1'b1) end_sim;
    @(posedge clk_sys) remote_dom <= 1'b0;
    #1 chk("woken", 0, sleep_mode);
    rd(8'h00, 8'h02, 8'h00, "slp_req_clr");
    rd(8'h01, 8'h02, 8'h00, "slp_ack_clr");
    $display("test wake done");
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (3) @(posedge clk_sys);
    reset <= 1'b0;
    t_reset;
    t_sleep;
    t_init;
    t_resync(1'b1, 8'd128);
    t_pins;
    t_resync(1'b0, 8'd1);
    t_wake;
    end_sim;
  end
  initial begin
    #400us;
    mismatches++;
    end_sim;
  end
endmodule

// ### include/cmc_link_if.sv
interface cmc_link_if;
  logic rx_level;
  logic sleep_active;
  logic filter_sel;
  logic wake_hit;
  logic resync_run;
  logic bus_off;
  logic rec11_seen;
  logic synced;

  modport wake (input rx_level, sleep_active, filter_sel, output wake_hit);
  modport sync (input resync_run, bus_off, rec11_seen, output synced);
  modport ctl  (output rx_level, sleep_active, filter_sel, resync_run,
                bus_off, rec11_seen, input wake_hit, synced);
endinterface

// ### include/cmc_pkg.sv
package cmc_pkg;

  // Register offsets
  localparam logic [7:0] OFS_CTL0   = 8'h00;
  localparam logic [7:0] OFS_CTL1   = 8'h01;
  localparam logic [7:0] OFS_BTR0   = 8'h02;
  localparam logic [7:0] OFS_STATUS = 8'h04;

  // Mode control 0 fields
  localparam int BIT_INIT_REQUEST = 0;
  localparam int BIT_SLEEP_REQUEST = 1;
  localparam int BIT_WAKE_ENABLE  = 2;
  localparam int BIT_STOP_IN_WAIT = 5;

  // Mode control 1 fields
  localparam int BIT_INIT_ACK     = 0;
  localparam int BIT_SLEEP_ACK    = 1;
  localparam int BIT_WAKE_FILTER  = 2;
  localparam int BIT_BUSOFF_POL   = 3;
  localparam int BIT_LISTEN       = 4;
  localparam int BIT_LOOPBACK     = 5;
  localparam int BIT_CLOCK_SELECT = 6;
  localparam int BIT_MODULE_EN    = 7;

  // Bit timing 0 fields
  localparam int BTR0_SJW_LSB = 6;
  localparam int BTR0_BRP_MSB = 5;

  // Status fields
  localparam int STAT_RX_LSB = 6;
  localparam int STAT_TX_LSB = 4;

  // Reset values
  localparam logic [7:0] CTL0_RESET = 8'h00;
  localparam logic [4:0] CTL1_RESET = 5'h00;
  localparam logic [7:0] BTR0_RESET = 8'h00;

  // Wake-up filter pulse time
  localparam int WAKE_PULSE_TIME_NS = 2000;
  localparam int CLK_PERIOD_NS      = 5;
  localparam int WAKE_PULSE_CYCLES  =
    (WAKE_PULSE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Resynchronisation counts of 11-recessive-bit sequences
  localparam logic [7:0] RESYNC_NORMAL = 8'h01;
  localparam logic [7:0] RESYNC_BUSOFF = 8'h80;

  typedef enum logic [1:0] {
    ST_RUN    = 2'b00,
    ST_SLEEP  = 2'b01,
    ST_INIT   = 2'b11,
    ST_RESYNC = 2'b10
  } cmc_state_t;

endpackage

// ### verilog/cmc_mode_ctrl.sv
module cmc_mode_ctrl (
  input  wire logic       clk_sys,
  input  wire logic       reset,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       special_mode,
  input  wire logic       cpu_wait,
  input  wire logic       cpu_stop,
  input  wire logic       bus_idle,
  input  wire logic       bus_off,
  input  wire logic       rec11_seen,
  input  wire logic [1:0] tx_state_field,
  input  wire logic [1:0] rx_state_field,
  input  wire logic       eng_tx_bit,
  output logic            eng_rx_bit,
  input  wire logic       bus_rx_pin,
  output logic            bus_tx_pin,
  output logic            module_enable,
  output logic            clock_select,
  output logic            loopback_test,
  output logic            listen_only,
  output logic            ack_err_send_en,
  output logic            err_cnt_freeze,
  output logic            tx_enable,
  output logic            busoff_recovery_policy,
  output logic      [1:0] sync_jump_width,
  output logic      [5:0] baud_prescaler,
  output logic            frame_abort,
  output logic            sleep_mode,
  output logic            bus_synced,
  output logic            wake_event
);

  cmc_link_if lnk ();

  ////////////////////////////////////////////////////////////////////////////
  // Register state

  cmc_pkg::cmc_state_t state_q;
  cmc_pkg::cmc_state_t state_d;

  logic       init_request_q;
  logic       init_request_d;
  logic       sleep_request_q;
  logic       sleep_request_d;
  logic       wake_enable_q;
  logic       wake_enable_d;
  logic       stop_in_wait_q;
  logic       stop_in_wait_d;
  logic [6:2] ctl1_q;
  logic [6:2] ctl1_d;
  logic       enable_locked_q;
  logic       enable_locked_d;
  logic       module_enable_q;
  logic       module_enable_d;
  logic [7:0] btr0_q;
  logic [7:0] btr0_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;

  logic       init_ack;
  logic       sleep_ack;
  logic       in_init;
  logic       in_sleep;
  logic       wr_ctl0;
  logic       wr_ctl1;
  logic       wr_btr0;
  logic       wake_now;
  logic       tx_force;
  logic [7:0] ctl0_view;
  logic [7:0] ctl1_view;
  logic [7:0] stat_view;

  ////////////////////////////////////////////////////////////////////////////
  // Mode handshake flags

  assign init_ack  = (state_q == cmc_pkg::ST_INIT);
  assign sleep_ack = (state_q == cmc_pkg::ST_SLEEP);
  assign in_init   = init_request_q && init_ack;
  assign in_sleep  = sleep_request_q && sleep_ack;

  assign wr_ctl0 = reg_wr && (reg_addr == cmc_pkg::OFS_CTL0);
  assign wr_ctl1 = reg_wr && (reg_addr == cmc_pkg::OFS_CTL1) && in_init;
  assign wr_btr0 = reg_wr && (reg_addr == cmc_pkg::OFS_BTR0) && in_init;

  // Wake only counts while wake enable is set during sleep
  assign wake_now = in_sleep && wake_enable_q && lnk.wake_hit;

  ////////////////////////////////////////////////////////////////////////////
  // Submodules

  assign lnk.rx_level     = bus_rx_pin;
  assign lnk.sleep_active = in_sleep;
  assign lnk.filter_sel   = ctl1_q[cmc_pkg::BIT_WAKE_FILTER];
  assign lnk.resync_run   = (state_q == cmc_pkg::ST_RESYNC);
  assign lnk.bus_off      = bus_off;
  assign lnk.rec11_seen   = rec11_seen;

  cmc_wake_filter u_wake (
    .clk_sys (clk_sys),
    .reset   (reset),
    .lnk     (lnk.wake)
  );

  cmc_resync u_resync (
    .clk_sys (clk_sys),
    .reset   (reset),
    .lnk     (lnk.sync)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Mode state machine

  always_comb begin
    state_d = state_q;
    case (state_q)
      cmc_pkg::ST_RUN: begin
        if (init_request_q) begin
          state_d = cmc_pkg::ST_INIT;
        end else if (sleep_request_q && bus_idle) begin
          state_d = cmc_pkg::ST_SLEEP;
        end
      end
      cmc_pkg::ST_SLEEP: begin
        // Init from sleep is the safe path
        if (init_request_q) begin
          state_d = cmc_pkg::ST_INIT;
        end else if (!sleep_request_q || wake_now) begin
          state_d = cmc_pkg::ST_RUN;
        end
      end
      cmc_pkg::ST_INIT: begin
        if (!init_request_q) begin
          state_d = cmc_pkg::ST_RESYNC;
        end
      end
      cmc_pkg::ST_RESYNC: begin
        if (init_request_q) begin
          state_d = cmc_pkg::ST_INIT;
        end else if (lnk.synced) begin
          state_d = cmc_pkg::ST_RUN;
        end
      end
      default: begin
        state_d = cmc_pkg::ST_RUN;
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state_q <= cmc_pkg::ST_RUN;
    end else begin
      state_q <= state_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode control 0

  always_comb begin
    init_request_d  = init_request_q;
    sleep_request_d = sleep_request_q;
    wake_enable_d   = wake_enable_q;
    stop_in_wait_d  = stop_in_wait_q;
    if (wake_now) begin
      sleep_request_d = 1'b0;
    end
    if (wr_ctl0) begin
      if (reg_wdata[cmc_pkg::BIT_INIT_REQUEST]) begin
        init_request_d = 1'b1;
      end else if (in_init) begin
        init_request_d = 1'b0;
      end
      // Software set beats the wake clear
      if (reg_wdata[cmc_pkg::BIT_SLEEP_REQUEST]) begin
        sleep_request_d = 1'b1;
      end else if (in_sleep) begin
        sleep_request_d = 1'b0;
      end
      wake_enable_d  = reg_wdata[cmc_pkg::BIT_WAKE_ENABLE];
      stop_in_wait_d = reg_wdata[cmc_pkg::BIT_STOP_IN_WAIT];
    end
    // Init entry resets only the unprotected bits
    if (state_q != cmc_pkg::ST_INIT &&
        state_d == cmc_pkg::ST_INIT) begin
      stop_in_wait_d = cmc_pkg::CTL0_RESET[cmc_pkg::BIT_STOP_IN_WAIT];
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      init_request_q  <= cmc_pkg::CTL0_RESET[cmc_pkg::BIT_INIT_REQUEST];
      sleep_request_q <= cmc_pkg::CTL0_RESET[cmc_pkg::BIT_SLEEP_REQUEST];
      wake_enable_q   <= cmc_pkg::CTL0_RESET[cmc_pkg::BIT_WAKE_ENABLE];
      stop_in_wait_q  <= cmc_pkg::CTL0_RESET[cmc_pkg::BIT_STOP_IN_WAIT];
    end else begin
      init_request_q  <= init_request_d;
      sleep_request_q <= sleep_request_d;
      wake_enable_q   <= wake_enable_d;
      stop_in_wait_q  <= stop_in_wait_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode control 1 and bit timing 0

  always_comb begin
    ctl1_d          = ctl1_q;
    module_enable_d = module_enable_q;
    enable_locked_d = enable_locked_q;
    btr0_d          = btr0_q;
    if (wr_ctl1) begin
      ctl1_d = reg_wdata[cmc_pkg::BIT_CLOCK_SELECT:
                         cmc_pkg::BIT_WAKE_FILTER];
      // Enable takes one write unless in special mode
      if (special_mode || !enable_locked_q) begin
        module_enable_d = reg_wdata[cmc_pkg::BIT_MODULE_EN];
        enable_locked_d = !special_mode;
      end
    end
    if (wr_btr0) begin
      btr0_d = reg_wdata;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      ctl1_q          <= cmc_pkg::CTL1_RESET;
      module_enable_q <= 1'b0;
      enable_locked_q <= 1'b0;
      btr0_q          <= cmc_pkg::BTR0_RESET;
    end else begin
      ctl1_q          <= ctl1_d;
      module_enable_q <= module_enable_d;
      enable_locked_q <= enable_locked_d;
      btr0_q          <= btr0_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path

  always_comb begin
    ctl0_view = 8'h00;
    ctl0_view[cmc_pkg::BIT_INIT_REQUEST]  = init_request_q;
    ctl0_view[cmc_pkg::BIT_SLEEP_REQUEST] = sleep_request_q;
    ctl0_view[cmc_pkg::BIT_WAKE_ENABLE]   = wake_enable_q;
    ctl0_view[cmc_pkg::BIT_STOP_IN_WAIT]  = stop_in_wait_q;
    ctl1_view = {module_enable_q,
                 ctl1_q[cmc_pkg::BIT_CLOCK_SELECT:cmc_pkg::BIT_WAKE_FILTER],
                 sleep_ack, init_ack};
    stat_view = 8'h00;
    // State fields are passed through untouched by init
    stat_view[cmc_pkg::STAT_RX_LSB +: 2] = rx_state_field;
    stat_view[cmc_pkg::STAT_TX_LSB +: 2] = tx_state_field;
  end

  always_comb begin
    rdata_d = 8'h00;
    if (!reg_rd) begin
      rdata_d = 8'h00;
    end else if (reg_addr == cmc_pkg::OFS_CTL0) begin
      rdata_d = ctl0_view;
    end else if (reg_addr == cmc_pkg::OFS_CTL1) begin
      rdata_d = ctl1_view;
    end else if (reg_addr == cmc_pkg::OFS_BTR0) begin
      rdata_d = btr0_q;
    end else if (reg_addr == cmc_pkg::OFS_STATUS) begin
      rdata_d = stat_view;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // Bus pins and engine controls

  // Forcing is combinational so the pin goes recessive at once
  assign tx_force = cpu_stop ||
                    (cpu_wait && stop_in_wait_q) ||
                    init_request_q ||
                    ctl1_q[cmc_pkg::BIT_LOOPBACK] ||
                    ctl1_q[cmc_pkg::BIT_LISTEN] ||
                    !module_enable_q;

  assign bus_tx_pin = tx_force || eng_tx_bit;

  assign eng_rx_bit = ctl1_q[cmc_pkg::BIT_LOOPBACK] ? eng_tx_bit
                                                    : bus_rx_pin;

  assign module_enable = module_enable_q;
  assign clock_select  = ctl1_q[cmc_pkg::BIT_CLOCK_SELECT];
  // Engine ignores ack slot and raises tx and rx events
  assign loopback_test = ctl1_q[cmc_pkg::BIT_LOOPBACK];
  assign listen_only   = ctl1_q[cmc_pkg::BIT_LISTEN];
  assign ack_err_send_en = !ctl1_q[cmc_pkg::BIT_LISTEN];
  assign err_cnt_freeze  = ctl1_q[cmc_pkg::BIT_LISTEN];
  assign tx_enable = module_enable_q && !ctl1_q[cmc_pkg::BIT_LISTEN] &&
                     (state_q == cmc_pkg::ST_RUN);
  assign busoff_recovery_policy = ctl1_q[cmc_pkg::BIT_BUSOFF_POL];
  assign sync_jump_width = btr0_q[7:cmc_pkg::BTR0_SJW_LSB];
  assign baud_prescaler  = btr0_q[cmc_pkg::BTR0_BRP_MSB:0];
  assign frame_abort = init_request_q;
  assign sleep_mode  = in_sleep;
  assign bus_synced  = (state_q == cmc_pkg::ST_RUN);
  assign wake_event  = wake_now;

endmodule

// ### verilog/cmc_resync.sv
module cmc_resync (
  input  wire logic  clk_sys,
  input  wire logic  reset,
  cmc_link_if.sync   lnk
);

  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  logic [7:0] need;

  // One sequence normally, 128 while bus-off
  assign need = lnk.bus_off ? cmc_pkg::RESYNC_BUSOFF
                            : cmc_pkg::RESYNC_NORMAL;

  always_comb begin
    cnt_d = cnt_q;
    if (!lnk.resync_run) begin
      cnt_d = 8'h00;
    end else if (lnk.rec11_seen && cnt_q != 8'hff) begin
      cnt_d = cnt_q + 8'h01;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      cnt_q <= 8'h00;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign lnk.synced = lnk.resync_run && lnk.rec11_seen &&
                      (cnt_q + 8'h01 >= need);

endmodule

// ### verilog/cmc_wake_filter.sv
module cmc_wake_filter (
  input  wire logic  clk_sys,
  input  wire logic  reset,
  cmc_link_if.wake   lnk
);

  localparam logic [15:0] WAKE_LAST =
    16'(cmc_pkg::WAKE_PULSE_CYCLES - 1);

  logic [15:0] cnt_q;
  logic [15:0] cnt_d;
  logic        dominant;

  assign dominant = lnk.sleep_active && !lnk.rx_level;

  always_comb begin
    cnt_d = 16'h0000;
    if (dominant && cnt_q != WAKE_LAST) begin
      cnt_d = cnt_q + 16'h0001;
    end else if (dominant) begin
      cnt_d = cnt_q;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      cnt_q <= 16'h0000;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // Any dominant level, or one held for the whole filter time
  assign lnk.wake_hit = dominant &&
    (!lnk.filter_sel || cnt_q == WAKE_LAST);

endmodule
